// file: bench/pmc_assertions.sv
// Purpose: Port assertions for the power mode controller.
// Assumes: One clock domain.
// Notes:   Bound to pmc_top.
`timescale 1ns/1ns
`default_nettype none
module pmc_assertions (
  input wire logic                          mclk,
  input wire logic                          reset_pin,
  input wire logic                          supply_ok,
  input wire logic                          supply_monitor_en,
  input wire logic                          cpu_wait_req,
  input wire logic [pmc_pkg::EXT_LINES-1:0] external_event_lines,
  input wire logic                          reset_pin_n,
  input wire pmc_pkg::pmc_reg_mode_t        core_regulator_mode_q,
  input wire logic                          chip_reset_n_q,
  input wire logic                          cpu_clk_en_q,
  input wire logic                          core_clk_en_q,
  input wire logic                          pll_en_q,
  input wire logic                          supply_monitor_irq_q,
  input wire pmc_pkg::pmc_state_t           state_q
);
  import pmc_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_pin);
  sequence s_stop_ev; state_q == PMC_ST_STOP && |external_event_lines && supply_ok; endsequence
  sequence s_mon_off; !supply_monitor_en ##1 !supply_monitor_en; endsequence
  property p_lowsup; !supply_ok |-> ##[1:3] !chip_reset_n_q; endproperty
  a_lowsup: assert property (p_lowsup) else $error("reset not held");
  property p_regset; core_regulator_mode_q inside {PMC_REG_NORMAL, PMC_REG_LOWPWR, PMC_REG_OFF}; endproperty
  a_regset: assert property (p_regset) else $error("bad regulator code");
  property p_runreg; state_q inside {PMC_ST_RUN, PMC_ST_SLEEP} |-> core_regulator_mode_q == PMC_REG_NORMAL; endproperty
  a_runreg: assert property (p_runreg) else $error("regulator not normal");
  property p_offonly; core_regulator_mode_q == PMC_REG_OFF |-> state_q == PMC_ST_STANDBY; endproperty
  a_offonly: assert property (p_offonly) else $error("regulator off outside standby");
  property p_sleep; state_q == PMC_ST_SLEEP |-> !cpu_clk_en_q && core_clk_en_q && pll_en_q; endproperty
  a_sleep: assert property (p_sleep) else $error("sleep clocks wrong");
  property p_stop; state_q == PMC_ST_STOP |-> !(core_clk_en_q || pll_en_q); endproperty
  a_stop: assert property (p_stop) else $error("stop clocks running");
  property p_entry; state_q == PMC_ST_RUN && !cpu_wait_req |=> state_q inside {PMC_ST_RUN, PMC_ST_RESET};
  endproperty
  a_entry: assert property (p_entry) else $error("entry without request");
  property p_stopwake; s_stop_ev |=> state_q == PMC_ST_RUN; endproperty
  a_stopwake: assert property (p_stopwake) else $error("no wake from stop");
  property p_stbyexit; state_q == PMC_ST_STANDBY && !reset_pin_n |=> state_q == PMC_ST_RESET; endproperty
  a_stbyexit: assert property (p_stbyexit) else $error("no standby exit");
  property p_rstreg; $rose(chip_reset_n_q) |-> core_regulator_mode_q == PMC_REG_NORMAL; endproperty
  a_rstreg: assert property (p_rstreg) else $error("regulator not normal after reset");
  property p_monoff; s_mon_off |-> !supply_monitor_irq_q; endproperty
  a_monoff: assert property (p_monoff) else $error("monitor irq while off");
endmodule
bind pmc_top pmc_assertions pmc_assertions_inst (.mclk, .reset_pin, .supply_ok, .supply_monitor_en, .cpu_wait_req,
  .external_event_lines, .reset_pin_n, .core_regulator_mode_q, .chip_reset_n_q, .cpu_clk_en_q, .core_clk_en_q,
  .pll_en_q, .supply_monitor_irq_q, .state_q);
`default_nettype wire

// file: bench/pmc_cpu_model.sv
// Purpose: Processor core model that raises the wait request.
// Assumes: go comes from the bench as a level.
// Notes:   Drops the request once the block has left RUN.
`timescale 1ns/1ns
`default_nettype none
module pmc_cpu_model (
  input  wire logic                mclk,
  input  wire logic                go,
  input  wire pmc_pkg::pmc_state_t state_q,
  output logic                     cpu_wait_req
);
  import pmc_pkg::*;
  // Changes only after an edge so the block samples a settled level.
  always @(posedge mclk) begin
    cpu_wait_req <= go && state_q == PMC_ST_RUN;
  end
endmodule
`default_nettype wire

// file: bench/pmc_top_tb.sv
// Purpose: Self-checking bench for the power mode controller.
// Assumes: Inputs change on the falling edge.
// Notes:   Short reset stretch keeps the run brief.
`timescale 1ns/1ns
`default_nettype none
module pmc_top_tb;
  import pmc_pkg::*;
  localparam int HOLD = 4;
  logic mclk = 1'b0, reset_pin = 1'b0, supply_ok = 1'b0, supply_above_thr = 1'b1, supply_monitor_en = 1'b0, go = 1'b0;
  logic supply_monitor_on_fall = 1'b0, supply_monitor_on_rise = 1'b0, stop_lowpwr_sel = 1'b0, cpu_irq_or_event = 1'b0;
  logic reset_pin_n = 1'b1, watchdog_reset = 1'b0, wake_pin = 1'b0, boot_select_low = 1'b0, boot_select_high = 1'b0;
  logic [1:0] lp_mode_sel = 2'h0, boot_source_q;
  logic [18:0] wk = '0;
  logic cpu_wait_req, chip_reset_n_q, cpu_clk_en_q, core_clk_en_q, pll_en_q, internal_fast_osc_en_q;
  logic external_fast_osc_en_q, backup_domain_keep_q, supply_monitor_irq_q, supply_monitor_level_q;
  pmc_reg_mode_t core_regulator_mode_q;
  pmc_state_t state_q;
  int bad_count = 0, num_checks = 0, cyc = 0;
  int wl[6] = '{0, 7, 15, 16, 17, 18};
  pmc_top #(.HOLD_CYC(HOLD)) pmc_top_inst (.mclk, .reset_pin, .supply_ok, .supply_above_thr, .supply_monitor_en,
    .supply_monitor_on_fall, .supply_monitor_on_rise, .lp_mode_sel, .stop_lowpwr_sel, .cpu_wait_req,
    .cpu_irq_or_event, .external_event_lines(wk[15:0]), .calendar_alarm(wk[16]), .usb_otg_port_wake(wk[17]),
    .analog_comparator_wake(wk[18]), .reset_pin_n, .watchdog_reset, .wake_pin, .boot_select_low, .boot_select_high,
    .core_regulator_mode_q, .chip_reset_n_q, .cpu_clk_en_q, .core_clk_en_q, .pll_en_q, .internal_fast_osc_en_q,
    .external_fast_osc_en_q, .backup_domain_keep_q, .supply_monitor_irq_q, .supply_monitor_level_q,
    .boot_source_q, .state_q);
  pmc_cpu_model pmc_cpu_model_inst (.mclk, .go, .state_q, .cpu_wait_req);
  always #10 mclk = ~mclk;
  task print_verdict;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      print_verdict();
    end
  end
  task chk(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask
  task wait_st(input pmc_state_t s);
    int n;
    n = 0;
    while (state_q !== s && n < 40) begin
      @(negedge mclk);
      n++;
    end
    chk(state_q === s, "state wait");
  endtask
  task enter(input logic [1:0] m, input pmc_state_t s);
    lp_mode_sel = m;
    go = 1'b1;
    wait_st(s);
    go = 1'b0;
  endtask
  task t_reset;
    repeat (21) @(negedge mclk);
    reset_pin = 1'b1;
    repeat (10) @(negedge mclk);
    chk(chip_reset_n_q === 1'b0 && state_q === PMC_ST_RESET, "low supply");
    supply_ok = 1'b1;
    wait_st(PMC_ST_RUN);
    chk(core_regulator_mode_q === PMC_REG_NORMAL && chip_reset_n_q === 1'b1, "run entry");
    supply_ok = 1'b0;
    @(negedge mclk);
    supply_ok = 1'b1;
    chk(state_q === PMC_ST_RESET, "brownout");
    wait_st(PMC_ST_RUN);
  endtask
  task t_sleep;
    cpu_irq_or_event = 1'b1;
    go = 1'b1;
    repeat (4) @(negedge mclk);
    chk(state_q === PMC_ST_RUN, "entry refused");
    cpu_irq_or_event = 1'b0;
    enter(2'h3, PMC_ST_SLEEP);
    chk({cpu_clk_en_q, core_clk_en_q, pll_en_q} === 3'h3, "sleep clocks");
    repeat (5) @(negedge mclk);
    chk(state_q === PMC_ST_SLEEP && core_regulator_mode_q === PMC_REG_NORMAL, "sleep hold");
    cpu_irq_or_event = 1'b1;
    @(negedge mclk);
    cpu_irq_or_event = 1'b0;
    chk(state_q === PMC_ST_RUN && cpu_clk_en_q === 1'b1, "sleep wake");
    enter(2'h0, PMC_ST_SLEEP);
    wk[5] = 1'b1;
    @(negedge mclk);
    wk = '0;
    chk(state_q === PMC_ST_RUN && cpu_clk_en_q === 1'b1, "sleep event wake");
  endtask
  task t_stop;
    for (int i = 0; i < 6; i++) begin
      stop_lowpwr_sel = i[0];
      enter(LPSEL_STOP, PMC_ST_STOP);
      chk({core_clk_en_q, pll_en_q, internal_fast_osc_en_q, external_fast_osc_en_q} === 4'h0, "stop clk");
      chk(core_regulator_mode_q === (i[0] ? PMC_REG_LOWPWR : PMC_REG_NORMAL), "stop reg");
      repeat (3) @(negedge mclk);
      chk(state_q === PMC_ST_STOP && backup_domain_keep_q === 1'b1, "stop hold");
      wk[wl[i]] = 1'b1;
      @(negedge mclk);
      wk = '0;
      chk(state_q === PMC_ST_RUN && core_regulator_mode_q === PMC_REG_NORMAL, "stop wake");
    end
  endtask
  task t_stby;
    logic [1:0] b;
    for (int k = 0; k < 4; k++) begin
      b = k[1:0] ^ (k[1:0] >> 1);
      {boot_select_high, boot_select_low} = b;
      enter(LPSEL_STANDBY, PMC_ST_STANDBY);
      chk(core_regulator_mode_q === PMC_REG_OFF && {chip_reset_n_q, pll_en_q} === 2'h0, "standby");
      repeat (3) @(negedge mclk);
      chk(state_q === PMC_ST_STANDBY && backup_domain_keep_q === 1'b1, "standby hold");
      reset_pin_n = (k != 0);
      watchdog_reset = (k == 1);
      wake_pin = (k == 2);
      wk[16] = (k == 3);
      @(negedge mclk);
      chk(state_q === PMC_ST_RESET, "standby exit");
      reset_pin_n = 1'b1;
      watchdog_reset = 1'b0;
      wake_pin = 1'b0;
      wk = '0;
      wait_st(PMC_ST_RUN);
      @(negedge mclk);
      chk(boot_source_q === (b[0] ? (b[1] ? BOOT_SRAM : BOOT_SYSMEM) : BOOT_FLASH), "boot");
      chk(core_regulator_mode_q === PMC_REG_NORMAL, "reg after reset");
    end
  endtask
  task t_mon;
    int n;
    for (int c = 0; c < 4; c++) begin
      supply_monitor_en = (c != 0);
      supply_monitor_on_fall = c[0] | (c == 0);
      supply_monitor_on_rise = c[1] | (c == 0);
      repeat (3) @(negedge mclk);
      n = 0;
      for (int j = 0; j < 8; j++) begin
        supply_above_thr = (j > 3);
        @(negedge mclk);
        if (supply_monitor_irq_q === 1'b1) n++;
        if (j == 2) chk(supply_monitor_level_q === (c == 0), "level");
      end
      chk(n == (c == 0 ? 0 : c[0] + c[1]), "irq count");
    end
  endtask
  initial begin
    t_reset();
    t_sleep();
    t_stop();
    t_stby();
    t_mon();
    print_verdict();
  end
endmodule
`default_nettype wire

// file: design/pmc_pkg.sv
// Purpose: Shared constants and types for the power mode controller.
// Assumes: One 50 MHz clock; all pin and analog inputs are synchronous to it.
// Notes:   Boot select and regulator codes are encodings local to this block.
package pmc_pkg;
  localparam int           RST_HOLD_NS     = 1000;
  localparam int           CLK_PERIOD_NS   = 20;
  localparam int           RST_HOLD_CYC    = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int           EXT_LINES       = 16;
  localparam logic [1:0]   BOOT_FLASH      = 2'h0;
  localparam logic [1:0]   BOOT_SYSMEM     = 2'h1;
  localparam logic [1:0]   BOOT_SRAM       = 2'h2;
  localparam logic [1:0]   LPSEL_STOP      = 2'h1;
  localparam logic [1:0]   LPSEL_STANDBY   = 2'h2;

  typedef enum logic [1:0] {
    PMC_REG_NORMAL = 2'h0,
    PMC_REG_LOWPWR = 2'h1,
    PMC_REG_OFF    = 2'h2
  } pmc_reg_mode_t;

  typedef enum logic [4:0] {
    PMC_ST_RESET   = 5'h01,
    PMC_ST_RUN     = 5'h02,
    PMC_ST_SLEEP   = 5'h04,
    PMC_ST_STOP    = 5'h08,
    PMC_ST_STANDBY = 5'h10
  } pmc_state_t;
endpackage

// file: design/pmc_supply_monitor.sv
// Purpose: Supply monitor with edge selection and enable.
// Assumes: above_thr is a clean synchronous comparator output.
// Notes:   Reference value is sampled every cycle and en_q gates the first enabled cycle, so turning it on raises no event.
`timescale 1ns/1ns
`default_nettype none
module pmc_supply_monitor (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic enable,
  input  wire logic on_fall,
  input  wire logic on_rise,
  input  wire logic above_thr,
  output logic      irq_q,
  output logic      level_q
);
  logic prev_q;
  logic en_q;
  // Both the old and the current enable gate a crossing, so no stray pulse follows a disable.
  wire  fell = en_q && enable && prev_q && !above_thr;
  wire  rose = en_q && enable && !prev_q && above_thr;
  wire  hit  = (fell && on_fall) || (rose && on_rise);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prev_q  <= 1'b1;
      en_q    <= 1'b0;
      irq_q   <= 1'b0;
      level_q <= 1'b1;
    end else begin
      en_q    <= enable;
      prev_q  <= above_thr;
      irq_q   <= hit;
      level_q <= enable ? above_thr : 1'b1;
    end
  end
endmodule
`default_nettype wire

// file: design/pmc_top.sv
// Purpose: Power mode controller: reset hold, regulator mode, low-power states, wakeup, boot select.
// Assumes: Inputs synchronous to mclk; supply_ok comes from the brownout_reset comparator.
// Notes:   Backup registers live outside the core reset and are never cleared here.
`timescale 1ns/1ns
`default_nettype none
//Function
//- Hold chip reset while supply is low; release only after adequate supply.
//- Supply monitor interrupts on falling, rising or both crossings as configured.
//- Supply monitor stays inactive until software enables it.
//- Core regulator has exactly three modes: normal, low-power, off.
//- Normal in run and sleep, selectable in stop, off only in standby.
//- Regulator returns to normal mode after any reset.
//- Sleep halts only the processor clock; any interrupt or event resumes.
//- Stop gates core clocks, PLL and fast oscillators, retaining contents.
//- Any of the external event lines wakes the device from stop.
//- Standby turns off regulator, PLL, oscillators; only backup domain survives.
//- Standby exits on reset pin low, watchdog reset, wake pin rise, alarm.
//- Backup calendar, watchdog and their clocks never stop in low power.
//- Boot select pins sampled at startup choose flash, boot memory or SRAM.
//- Backup registers survive system reset, power reset and standby wakeup.
module pmc_top #(
  parameter int HOLD_CYC = pmc_pkg::RST_HOLD_CYC
) (
  input  wire logic                          mclk,
  input  wire logic                          reset_pin,
  input  wire logic                          supply_ok,
  input  wire logic                          supply_above_thr,
  input  wire logic                          supply_monitor_en,
  input  wire logic                          supply_monitor_on_fall,
  input  wire logic                          supply_monitor_on_rise,
  input  wire logic [1:0]                    lp_mode_sel,
  input  wire logic                          stop_lowpwr_sel,
  input  wire logic                          cpu_wait_req,
  input  wire logic                          cpu_irq_or_event,
  input  wire logic [pmc_pkg::EXT_LINES-1:0] external_event_lines,
  input  wire logic                          calendar_alarm,
  input  wire logic                          usb_otg_port_wake,
  input  wire logic                          analog_comparator_wake,
  input  wire logic                          reset_pin_n,
  input  wire logic                          watchdog_reset,
  input  wire logic                          wake_pin,
  input  wire logic                          boot_select_low,
  input  wire logic                          boot_select_high,
  output pmc_pkg::pmc_reg_mode_t             core_regulator_mode_q,
  output logic                               chip_reset_n_q,
  output logic                               cpu_clk_en_q,
  output logic                               core_clk_en_q,
  output logic                               pll_en_q,
  output logic                               internal_fast_osc_en_q,
  output logic                               external_fast_osc_en_q,
  output logic                               backup_domain_keep_q,
  output logic                               supply_monitor_irq_q,
  output logic                               supply_monitor_level_q,
  output logic [1:0]                         boot_source_q,
  output pmc_pkg::pmc_state_t                state_q
);
  import pmc_pkg::*;

  localparam int CW = $clog2(HOLD_CYC + 1);

  logic          rs1_q;
  logic          rs2_q;
  logic [CW-1:0] hold_q;
  logic          wake_prev_q;
  logic          boot_done_q;
  pmc_state_t    state_d;
  pmc_reg_mode_t reg_d;

  function automatic pmc_reg_mode_t reg_for(input pmc_state_t st, input logic lp);
    unique case (st)
      PMC_ST_STOP:    reg_for = lp ? PMC_REG_LOWPWR : PMC_REG_NORMAL;
      PMC_ST_STANDBY: reg_for = PMC_REG_OFF;
      default:        reg_for = PMC_REG_NORMAL;
    endcase
  endfunction

  // Reset release is synchronised; the supply must hold good for the whole count.
  wire rst_n      = rs2_q;
  wire hold_done  = (hold_q == CW'(HOLD_CYC));
  wire wake_rise  = wake_pin && !wake_prev_q;
  wire stop_wake  = (|external_event_lines) || supply_monitor_irq_q || calendar_alarm
                    || usb_otg_port_wake || analog_comparator_wake;
  wire stby_wake  = !reset_pin_n || watchdog_reset || wake_rise || calendar_alarm;
  wire lp_req     = cpu_wait_req && !cpu_irq_or_event;
  wire [1:0] boot_pins = {boot_select_high, boot_select_low};
  wire [1:0] boot_dec  = !boot_pins[0] ? BOOT_FLASH : (boot_pins[1] ? BOOT_SRAM : BOOT_SYSMEM);

  // A brownout overrides every state, so a supply dip in any low-power state lands in reset.
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      PMC_ST_RESET:   if (hold_done) state_d = PMC_ST_RUN;
      PMC_ST_RUN: begin
        if (lp_req) begin
          if (lp_mode_sel == LPSEL_STANDBY) state_d = PMC_ST_STANDBY;
          else if (lp_mode_sel == LPSEL_STOP) state_d = PMC_ST_STOP;
          else state_d = PMC_ST_SLEEP;
        end
      end
      PMC_ST_SLEEP:   if (cpu_irq_or_event || stop_wake) state_d = PMC_ST_RUN;
      PMC_ST_STOP:    if (stop_wake) state_d = PMC_ST_RUN;
      PMC_ST_STANDBY: if (stby_wake) state_d = PMC_ST_RESET;
      default:        state_d = PMC_ST_RESET;
    endcase
    if (!supply_ok) state_d = PMC_ST_RESET;
  end

  assign reg_d = reg_for(state_d, stop_lowpwr_sel);

  always_ff @(posedge mclk or negedge reset_pin) begin
    if (!reset_pin) begin
      rs1_q <= 1'b0;
      rs2_q <= 1'b0;
    end else begin
      rs1_q <= 1'b1;
      rs2_q <= rs1_q;
    end
  end

  // The hold counter restarts whenever the supply dips, so a brownout stretches reset.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hold_q <= '0;
    end else if (state_q != PMC_ST_RESET || !supply_ok) begin
      hold_q <= '0;
    end else if (!hold_done) begin
      hold_q <= hold_q + CW'(1);
    end
  end

  // The regulator code follows the next state so it never lags a mode change by a cycle.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q               <= PMC_ST_RESET;
      core_regulator_mode_q <= PMC_REG_NORMAL;
    end else begin
      state_q               <= state_d;
      core_regulator_mode_q <= reg_d;
    end
  end

  // The edge detector resets to the pin's idle low level, so standby only sees a real rise.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wake_prev_q <= 1'b0;
    end else begin
      wake_prev_q <= wake_pin;
    end
  end

  // Enables follow the next state so they switch on the same edge as state_q.
  wire nx_reset     = (state_d == PMC_ST_RESET);
  wire nx_run       = (state_d == PMC_ST_RUN);
  wire nx_sleep     = (state_d == PMC_ST_SLEEP);
  wire nx_stop      = (state_d == PMC_ST_STOP);
  wire nx_stby      = (state_d == PMC_ST_STANDBY);
  wire nx_awake     = nx_run || nx_sleep;
  wire chip_rst_n_d = !nx_reset && !nx_stby;
  wire int_osc_d    = !nx_stop && !nx_stby;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      chip_reset_n_q <= 1'b0;
    end else begin
      chip_reset_n_q <= chip_rst_n_d;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_clk_en_q  <= 1'b0;
      core_clk_en_q <= 1'b0;
    end else begin
      cpu_clk_en_q  <= nx_run;
      core_clk_en_q <= nx_awake;
    end
  end

  // The internal oscillator runs through reset because the chip restarts on it.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pll_en_q               <= 1'b0;
      internal_fast_osc_en_q <= 1'b1;
      external_fast_osc_en_q <= 1'b0;
    end else begin
      pll_en_q               <= nx_awake;
      internal_fast_osc_en_q <= int_osc_d;
      external_fast_osc_en_q <= nx_awake;
    end
  end

  // The backup keep flag has no reset term: the backup domain sits outside every reset.
  always_ff @(posedge mclk) begin
    backup_domain_keep_q <= 1'b1;
  end

  // Boot pins are caught once, one cycle after reset is released to the chip.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      boot_done_q   <= 1'b0;
      boot_source_q <= BOOT_FLASH;
    end else if (state_q == PMC_ST_RESET) begin
      boot_done_q   <= 1'b0;
    end else if (!boot_done_q) begin
      boot_done_q   <= 1'b1;
      boot_source_q <= boot_dec;
    end
  end

  pmc_supply_monitor pmc_supply_monitor_inst (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .enable    (supply_monitor_en),
    .on_fall   (supply_monitor_on_fall),
    .on_rise   (supply_monitor_on_rise),
    .above_thr (supply_above_thr),
    .irq_q     (supply_monitor_irq_q),
    .level_q   (supply_monitor_level_q)
  );
endmodule
`default_nettype wire
